//--- hdl/cmb_pkg.sv
// Shared constants for the CAN mailbox, interrupt and bit timing block
package cmb_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_OBJ = 15;
	localparam int DATA_DEPTH = 8;
	localparam int BT_WIDTH = 22;
	// ----------------------------------------
	// Register word indices
	// ----------------------------------------
	localparam logic [3:0] REG_PAGE = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam logic [3:0] REG_DATA = 4'h3;
	localparam logic [3:0] REG_ENSUM = 4'h4;
	localparam logic [3:0] REG_GIE = 4'h5;
	localparam logic [3:0] REG_GIT = 4'h6;
	localparam logic [3:0] REG_OBJIE = 4'h7;
	localparam logic [3:0] REG_PEND = 4'h8;
	localparam logic [3:0] REG_BT = 4'h9;
	localparam logic [3:0] REG_SYSIE = 4'ha;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PAGE_OBJ_LSB = 4;
	localparam int CFG_LSB = 6;
	localparam int ST_RXDONE = 6;
	localparam int ST_TXDONE = 5;
	localparam int ST_BITERR = 4;
	localparam int ST_STUFFERR = 3;
	localparam int ST_CRCERR = 2;
	localparam int ST_FORMERR = 1;
	localparam int ST_ACKERR = 0;
	localparam int GIE_GLOBAL = 7;
	localparam int GIE_RX = 5;
	localparam int GIE_TX = 4;
	localparam int GIE_OBJERR = 3;
	localparam int GIE_BUF = 2;
	localparam int GIE_GENERR = 1;
	localparam int GIT_BUF = 2;
	localparam int GIT_TIM = 1;
	localparam int GIT_GENERR = 0;
	localparam int BT_PRS_LSB = 8;
	localparam int BT_PHASE_ONE_SEGMENT_LSB = 12;
	localparam int BT_PHASE_TWO_SEGMENT_LSB = 16;
	localparam int BT_SJW_LSB = 20;
	// ----------------------------------------
	// Encodings and reset values
	// ----------------------------------------
	localparam logic [1:0] CFG_DISABLED = 2'h0;
	localparam logic [1:0] CFG_TX = 2'h1;
	localparam logic [1:0] CFG_RX = 2'h2;
	localparam logic [1:0] CFG_RXBUF = 2'h3;
	localparam logic [2:0] ERR_BIT = 3'h0;
	localparam logic [2:0] ERR_STUFF = 3'h1;
	localparam logic [2:0] ERR_CRC = 3'h2;
	localparam logic [2:0] ERR_FORM = 3'h3;
	localparam logic [2:0] ERR_ACK = 3'h4;
	localparam logic [7:0] GIE_RESET = 8'h00;
	localparam logic [21:0] BT_RESET = 22'h000000;
	localparam int MAX_SJW_TQ = 4;
endpackage : cmb_pkg

//--- hdl/cmb_bit_timing.sv
// Time quantum prescaler, bit segment sequencer and resynchronisation
`timescale 1ns/10ps
`default_nettype none
module cmb_bit_timing (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [5:0] prescalerValue,
	input wire logic [2:0] propSeg,
	input wire logic [2:0] phaseOneSeg,
	input wire logic [2:0] phaseTwoSeg,
	input wire logic [1:0] resyncJumpWidth,
	input wire logic canRx,
	output logic timeQuantumTick,
	output logic sampleTick,
	output logic bitLevel
);
	typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} cmb_seg_t;
	typedef struct packed {
		logic [5:0] preCnt;
		cmb_seg_t seg;
		logic [3:0] segCnt;
		logic [3:0] ph1Ext;
		logic [3:0] ph2Cut;
		logic resynced;
		logic rxPrev;
		logic tq;
		logic sample;
		logic bitLvl;
	} cmb_bt_state_t;

	cmb_bt_state_t st_reg, st_next;
	logic tick, edgeSeen, segEnd;
	logic [3:0] propLen, ph1Len, ph2Len, sjwEff, segLen, ph2Left;

	always_comb begin
		st_next = st_reg;
		tick = (st_reg.preCnt == prescalerValue);
		propLen = {1'b0, propSeg} + 4'h1;
		ph1Len = {1'b0, phaseOneSeg} + 4'h1;
		ph2Len = {1'b0, phaseTwoSeg} + 4'h1;
		sjwEff = {2'b00, resyncJumpWidth} + 4'h1;
		if (ph1Len < sjwEff) begin
			sjwEff = ph1Len;
		end
		ph2Left = ph2Len - st_reg.segCnt - 4'h1;
		edgeSeen = st_reg.rxPrev && !canRx && !st_reg.resynced;
		case (st_reg.seg)
			SEG_SYNC: segLen = 4'h1;
			SEG_PROP: segLen = propLen;
			SEG_PH1: segLen = ph1Len + st_reg.ph1Ext;
			SEG_PH2: segLen = ph2Len - st_reg.ph2Cut;
			default: segLen = 4'h1;
		endcase
		segEnd = tick && (st_reg.segCnt + 4'h1 >= segLen);
		st_next.rxPrev = canRx;
		st_next.tq = tick;
		st_next.sample = 1'b0;
		st_next.preCnt = tick ? 6'h00 : st_reg.preCnt + 6'h01;
		// Resync by stretching phase one or trimming phase two
		if (edgeSeen && st_reg.seg != SEG_SYNC) begin
			st_next.resynced = 1'b1;
			if (st_reg.seg == SEG_PH2) begin
				st_next.ph2Cut = (ph2Left < sjwEff) ? ph2Left : sjwEff;
			end else begin
				st_next.ph1Ext = sjwEff;
			end
		end
		if (tick) begin
			st_next.segCnt = st_reg.segCnt + 4'h1;
		end
		if (segEnd) begin
			st_next.segCnt = 4'h0;
			case (st_reg.seg)
				SEG_SYNC: st_next.seg = SEG_PROP;
				SEG_PROP: st_next.seg = SEG_PH1;
				SEG_PH1: begin
					st_next.seg = SEG_PH2;
					st_next.sample = 1'b1;
					st_next.bitLvl = canRx;
				end
				SEG_PH2: begin
					st_next.seg = SEG_SYNC;
					st_next.ph1Ext = 4'h0;
					st_next.ph2Cut = 4'h0;
					st_next.resynced = 1'b0;
				end
				default: st_next.seg = SEG_SYNC;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '{preCnt: 6'h00, seg: SEG_SYNC, segCnt: 4'h0, ph1Ext: 4'h0,
				ph2Cut: 4'h0, resynced: 1'b0, rxPrev: 1'b1, tq: 1'b0,
				sample: 1'b0, bitLvl: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end

	assign timeQuantumTick = st_reg.tq;
	assign sampleTick = st_reg.sample;
	assign bitLevel = st_reg.bitLvl;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_prescale_bound: assert property (
		$stable(prescalerValue) |-> st_reg.preCnt <= prescalerValue)
		else $error("prescaler counter passed its limit");
	a_sample_boundary: assert property (
		sampleTick |-> st_reg.seg == SEG_PH2 && $past(st_reg.seg) == SEG_PH1)
		else $error("sample not at phase one to two boundary");
	a_jump_limit: assert property (
		st_reg.ph1Ext <= cmb_pkg::MAX_SJW_TQ && st_reg.ph2Cut <= cmb_pkg::MAX_SJW_TQ)
		else $error("resync jump wider than four quanta");
	a_sync_one_tq: assert property (
		st_reg.seg == SEG_SYNC && tick |=> st_reg.seg == SEG_PROP)
		else $error("sync segment not one quantum");
endmodule : cmb_bit_timing
`default_nettype wire

//--- hdl/cmb_mailbox.sv
// CAN message object mailbox with interrupt gating and bit timing
// Function
// - Page register selects one of fifteen objects for control and status windows.
// - Data window byte pointer steps by one per access, wrapping at eight.
// - Config field: 00 off, 01 transmit, 10 receive, 11 buffer member.
// - Writing a non-disabled config sets the object's active bit.
// - Completed transmit or receive clears active; software rewrites config to re-arm.
// - Any set of objects, even scattered, may form the receive buffer.
// - Buffer frames go to the lowest-numbered free member.
// - Buffer-full flag sets when every member is occupied.
// - While full, frames are dropped and member status left untouched.
// - Object interrupts need global, per-object and cause enables all set.
// - General error and buffer-full interrupts need global and own enable.
// - Timer overrun interrupt uses its own system enable only.
// - An object interrupt sets that object's pending bit.
// - Form error while transmitting also flags a bit error.
// - Object-recorded errors never set the general error flag.
// - Quantum is clock over prescaler plus one; sync lasts one quantum.
// - Propagation and phase one last field plus one quanta.
// - Phase two lasts field plus one; software keeps it within limits.
// - Jump width is field plus one, capped by phase one and four.
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module cmb_mailbox #(
	parameter int NUM_OBJ = cmb_pkg::NUM_OBJ,
	parameter int DATA_DEPTH = cmb_pkg::DATA_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rxFrameValid,
	input wire logic rxFrameToBuffer,
	input wire logic [3:0] rxFrameObj,
	input wire logic [63:0] rxFrameData,
	input wire logic txDoneValid,
	input wire logic [3:0] txDoneObj,
	input wire logic errValid,
	input wire logic errIsObject,
	input wire logic [3:0] errObj,
	input wire logic [2:0] errKind,
	input wire logic errWhileTx,
	input wire logic timerOverrun,
	input wire logic canRx,
	output logic irqOut,
	output logic timeQuantumTick,
	output logic sampleTick,
	output logic bitLevel
);
	localparam int PW = $clog2(DATA_DEPTH);

	typedef struct packed {
		logic [3:0] page;
		logic [PW-1:0] ptr;
		logic [NUM_OBJ-1:0][1:0] cfg;
		logic [NUM_OBJ-1:0] active;
		logic [NUM_OBJ-1:0][6:0] stat;
		logic [NUM_OBJ-1:0][DATA_DEPTH-1:0][7:0] mbox;
		logic [7:0] gie;
		logic [2:0] git;
		logic sysIe;
		logic [NUM_OBJ-1:0] objIe;
		logic [NUM_OBJ-1:0] pend;
		logic [cmb_pkg::BT_WIDTH-1:0] bt;
		logic irq;
		logic [31:0] rdata;
		logic waitReq;
	} cmb_state_t;

	cmb_state_t st_reg, st_next;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic objOk(input logic [3:0] idx);
		objOk = ({28'h0000000, idx} < NUM_OBJ);
	endfunction : objOk

	function automatic logic [NUM_OBJ-1:0] bufMembers(input logic [NUM_OBJ-1:0][1:0] cfg);
		for (int i = 0; i < NUM_OBJ; i++) begin
			bufMembers[i] = (cfg[i] == cmb_pkg::CFG_RXBUF);
		end
	endfunction : bufMembers

	logic acc, wr, rd, pageOk, fullNow, stored;
	logic [NUM_OBJ-1:0] members, freeSet;
	logic [3:0] freeIdx;
	logic [7:0] wb;

	always_comb begin
		st_next = st_reg;
		acc = (avs_read || avs_write) && st_reg.waitReq;
		wr = acc && avs_write && avs_byteenable[0];
		rd = acc && avs_read;
		wb = avs_writedata[7:0];
		pageOk = objOk(st_reg.page);
		members = bufMembers(st_reg.cfg);
		freeSet = members & st_reg.active;
		fullNow = (|members) && !(|freeSet);
		freeIdx = 4'h0;
		for (int i = NUM_OBJ - 1; i >= 0; i--) begin
			if (freeSet[i]) begin
				freeIdx = 4'(i);
			end
		end
		stored = 1'b0;
		st_next.waitReq = !acc;
		// ----------------------------------------
		// Register reads
		// ----------------------------------------
		if (rd) begin
			st_next.rdata = 32'h00000000;
			case (avs_address)
				cmb_pkg::REG_PAGE: st_next.rdata[7:0] =
					{st_reg.page, {(4 - PW){1'b0}}, st_reg.ptr};
				cmb_pkg::REG_CTRL: st_next.rdata[7:0] =
					pageOk ? {st_reg.cfg[st_reg.page], 6'h00} : 8'h00;
				cmb_pkg::REG_STAT: st_next.rdata[7:0] =
					pageOk ? {1'b0, st_reg.stat[st_reg.page]} : 8'h00;
				cmb_pkg::REG_DATA: begin
					st_next.rdata[7:0] = pageOk ? st_reg.mbox[st_reg.page][st_reg.ptr] : 8'h00;
					st_next.ptr = st_reg.ptr + 1'b1;
				end
				cmb_pkg::REG_ENSUM: st_next.rdata[NUM_OBJ-1:0] = st_reg.active;
				cmb_pkg::REG_GIE: st_next.rdata[7:0] = st_reg.gie;
				cmb_pkg::REG_GIT: st_next.rdata[2:0] = st_reg.git;
				cmb_pkg::REG_OBJIE: st_next.rdata[NUM_OBJ-1:0] = st_reg.objIe;
				cmb_pkg::REG_PEND: st_next.rdata[NUM_OBJ-1:0] = st_reg.pend;
				cmb_pkg::REG_BT: st_next.rdata[cmb_pkg::BT_WIDTH-1:0] = st_reg.bt;
				cmb_pkg::REG_SYSIE: st_next.rdata[0] = st_reg.sysIe;
				default: st_next.rdata = 32'h00000000;
			endcase
		end
		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		if (wr) begin
			case (avs_address)
				cmb_pkg::REG_PAGE: begin
					st_next.page = wb[7:cmb_pkg::PAGE_OBJ_LSB];
					st_next.ptr = wb[PW-1:0];
				end
				cmb_pkg::REG_CTRL: if (pageOk) begin
					st_next.cfg[st_reg.page] = wb[cmb_pkg::CFG_LSB +: 2];
					st_next.active[st_reg.page] =
						(wb[cmb_pkg::CFG_LSB +: 2] != cmb_pkg::CFG_DISABLED);
				end
				cmb_pkg::REG_STAT: if (pageOk) begin
					st_next.stat[st_reg.page] = wb[6:0];
				end
				cmb_pkg::REG_DATA: begin
					if (pageOk) begin
						st_next.mbox[st_reg.page][st_reg.ptr] = wb;
					end
					st_next.ptr = st_reg.ptr + 1'b1;
				end
				cmb_pkg::REG_GIE: st_next.gie = wb;
				cmb_pkg::REG_GIT: st_next.git = st_reg.git & ~wb[2:0];
				cmb_pkg::REG_OBJIE: st_next.objIe = avs_writedata[NUM_OBJ-1:0];
				cmb_pkg::REG_BT: st_next.bt = avs_writedata[cmb_pkg::BT_WIDTH-1:0];
				cmb_pkg::REG_SYSIE: st_next.sysIe = wb[0];
				default: st_next.sysIe = st_next.sysIe;
			endcase
		end
		// ----------------------------------------
		// Hardware events, applied after writes so they beat a same-cycle register write
		// ----------------------------------------
		if (txDoneValid && objOk(txDoneObj)) begin
			st_next.stat[txDoneObj][cmb_pkg::ST_TXDONE] = 1'b1;
			st_next.active[txDoneObj] = 1'b0;
		end
		if (rxFrameValid) begin
			if (rxFrameToBuffer) begin
				if (!fullNow && (|freeSet)) begin
					st_next.mbox[freeIdx] = rxFrameData;
					st_next.stat[freeIdx][cmb_pkg::ST_RXDONE] = 1'b1;
					st_next.active[freeIdx] = 1'b0;
					stored = 1'b1;
				end
			end else if (objOk(rxFrameObj) && st_reg.active[rxFrameObj]
				&& st_reg.cfg[rxFrameObj] == cmb_pkg::CFG_RX) begin
				st_next.mbox[rxFrameObj] = rxFrameData;
				st_next.stat[rxFrameObj][cmb_pkg::ST_RXDONE] = 1'b1;
				st_next.active[rxFrameObj] = 1'b0;
			end
		end
		if (stored && !(|(bufMembers(st_next.cfg) & st_next.active))) begin
			st_next.git[cmb_pkg::GIT_BUF] = 1'b1;
		end
		if (errValid) begin
			if (errIsObject && objOk(errObj)) begin
				case (errKind)
					cmb_pkg::ERR_BIT: st_next.stat[errObj][cmb_pkg::ST_BITERR] = 1'b1;
					cmb_pkg::ERR_STUFF: st_next.stat[errObj][cmb_pkg::ST_STUFFERR] = 1'b1;
					cmb_pkg::ERR_CRC: st_next.stat[errObj][cmb_pkg::ST_CRCERR] = 1'b1;
					cmb_pkg::ERR_FORM: begin
						st_next.stat[errObj][cmb_pkg::ST_FORMERR] = 1'b1;
						if (errWhileTx) begin
							st_next.stat[errObj][cmb_pkg::ST_BITERR] = 1'b1;
						end
					end
					cmb_pkg::ERR_ACK: st_next.stat[errObj][cmb_pkg::ST_ACKERR] = 1'b1;
					default: st_next.stat[errObj][cmb_pkg::ST_BITERR] = 1'b1;
				endcase
			end else begin
				st_next.git[cmb_pkg::GIT_GENERR] = 1'b1;
			end
		end
		if (timerOverrun) begin
			st_next.git[cmb_pkg::GIT_TIM] = 1'b1;
		end
		// ----------------------------------------
		// Interrupt gating
		// ----------------------------------------
		for (int i = 0; i < NUM_OBJ; i++) begin
			st_next.pend[i] = st_next.objIe[i] && (
				(st_next.stat[i][cmb_pkg::ST_RXDONE] && st_next.gie[cmb_pkg::GIE_RX])
				|| (st_next.stat[i][cmb_pkg::ST_TXDONE] && st_next.gie[cmb_pkg::GIE_TX])
				|| ((|st_next.stat[i][4:0]) && st_next.gie[cmb_pkg::GIE_OBJERR]));
		end
		st_next.irq = (st_next.gie[cmb_pkg::GIE_GLOBAL] && ((|st_next.pend)
			|| (st_next.git[cmb_pkg::GIT_GENERR] && st_next.gie[cmb_pkg::GIE_GENERR])
			|| (st_next.git[cmb_pkg::GIT_BUF] && st_next.gie[cmb_pkg::GIE_BUF])))
			|| (st_next.git[cmb_pkg::GIT_TIM] && st_next.sysIe);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.gie <= cmb_pkg::GIE_RESET;
			st_reg.bt <= cmb_pkg::BT_RESET;
			st_reg.waitReq <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.waitReq;
	assign irqOut = st_reg.irq;

	// ----------------------------------------
	// Bit timing
	// ----------------------------------------
	cmb_bit_timing cmb_bit_timing_inst (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.prescalerValue(st_reg.bt[5:0]),
		.propSeg(st_reg.bt[cmb_pkg::BT_PRS_LSB +: 3]),
		.phaseOneSeg(st_reg.bt[cmb_pkg::BT_PHASE_ONE_SEGMENT_LSB +: 3]),
		.phaseTwoSeg(st_reg.bt[cmb_pkg::BT_PHASE_TWO_SEGMENT_LSB +: 3]),
		.resyncJumpWidth(st_reg.bt[cmb_pkg::BT_SJW_LSB +: 2]),
		.canRx(canRx),
		.timeQuantumTick(timeQuantumTick),
		.sampleTick(sampleTick),
		.bitLevel(bitLevel)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_cfg_write;
		wr && avs_address == cmb_pkg::REG_CTRL && pageOk
			&& avs_writedata[cmb_pkg::CFG_LSB +: 2] != cmb_pkg::CFG_DISABLED
			&& !txDoneValid && !rxFrameValid;
	endsequence
	sequence s_form_in_tx;
		errValid && errIsObject && objOk(errObj) && errKind == cmb_pkg::ERR_FORM && errWhileTx;
	endsequence

	a_cfg_activates: assert property (
		s_cfg_write |=> st_reg.active[$past(st_reg.page)])
		else $error("config write left object inactive");
	a_ptr_steps: assert property (
		acc && avs_address == cmb_pkg::REG_DATA && (avs_read || avs_byteenable[0])
		|=> st_reg.ptr == $past(st_reg.ptr) + 1'b1)
		else $error("data pointer did not advance");
	a_tx_deactivates: assert property (
		txDoneValid && objOk(txDoneObj) && !(wr && avs_address == cmb_pkg::REG_CTRL)
		|=> !st_reg.active[$past(txDoneObj)])
		else $error("active bit kept after transmit done");
	a_full_drops: assert property (
		fullNow && rxFrameValid && rxFrameToBuffer && !txDoneValid && !errValid && !wr
		|=> $stable(st_reg.stat) && $stable(st_reg.mbox))
		else $error("frame stored while buffer full");
	a_form_twice: assert property (
		s_form_in_tx |=> st_reg.stat[$past(errObj)][cmb_pkg::ST_BITERR]
			&& st_reg.stat[$past(errObj)][cmb_pkg::ST_FORMERR])
		else $error("form error in transmit missed bit error");
	a_no_general: assert property (
		errValid && errIsObject && objOk(errObj) && !st_reg.git[cmb_pkg::GIT_GENERR]
		|=> !st_reg.git[cmb_pkg::GIT_GENERR])
		else $error("object error also set general error");
	a_irq_gated: assert property (
		irqOut && !(st_reg.git[cmb_pkg::GIT_TIM] && st_reg.sysIe)
		|-> st_reg.gie[cmb_pkg::GIE_GLOBAL])
		else $error("interrupt without global enable");
	a_timer_irq: assert property (
		st_reg.git[cmb_pkg::GIT_TIM] && st_reg.sysIe |-> irqOut)
		else $error("timer overrun interrupt missing");
	a_bus_answer: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle long");
	a_cfg_disable: assert property (
		wr && avs_address == cmb_pkg::REG_CTRL && pageOk
		&& avs_writedata[cmb_pkg::CFG_LSB +: 2] == cmb_pkg::CFG_DISABLED
		|=> !st_reg.active[$past(st_reg.page)])
		else $error("disabled object left active");
	a_rx_deactivates: assert property (
		rxFrameValid && !rxFrameToBuffer && objOk(rxFrameObj) && !wr
		&& st_reg.cfg[rxFrameObj] == cmb_pkg::CFG_RX |=> !st_reg.active[$past(rxFrameObj)])
		else $error("active kept after receive");
	a_full_flag: assert property (
		rxFrameValid && rxFrameToBuffer && $countones(freeSet) == 1 && !wr
		|=> st_reg.git[cmb_pkg::GIT_BUF])
		else $error("buffer full flag missing");
	a_pend_gated: assert property (
		!(|(st_reg.pend & ~st_reg.objIe)))
		else $error("pending without object enable");
	a_gen_irq: assert property (
		st_reg.git[cmb_pkg::GIT_GENERR] && st_reg.gie[cmb_pkg::GIE_GENERR]
		&& st_reg.gie[cmb_pkg::GIE_GLOBAL] |-> irqOut)
		else $error("general error interrupt missing");
	a_buf_irq: assert property (
		st_reg.git[cmb_pkg::GIT_BUF] && st_reg.gie[cmb_pkg::GIE_BUF]
		&& st_reg.gie[cmb_pkg::GIE_GLOBAL] |-> irqOut)
		else $error("buffer full interrupt missing");
	a_timer_flag: assert property (
		timerOverrun |=> st_reg.git[cmb_pkg::GIT_TIM])
		else $error("timer overrun flag missing");
endmodule : cmb_mailbox
`default_nettype wire

//--- sim/cmb_bus_node.sv
// Far-side model: bus line level and frame event pulses
`timescale 1ns/10ps
`default_nettype none
module cmb_bus_node (
	input wire logic sys_clk,
	output logic canRx,
	output logic rxFrameValid,
	output logic rxFrameToBuffer,
	output logic [3:0] rxFrameObj,
	output logic [63:0] rxFrameData,
	output logic txDoneValid,
	output logic [3:0] txDoneObj,
	output logic errValid,
	output logic errIsObject,
	output logic [3:0] errObj,
	output logic [2:0] errKind,
	output logic errWhileTx,
	output logic timerOverrun
);
	// Idle bus recessive, no frames
	initial begin
		canRx = 1'b1;
		{rxFrameValid, rxFrameToBuffer, rxFrameObj, rxFrameData} = '0;
		{txDoneValid, txDoneObj, errValid, errIsObject, errObj, errKind, errWhileTx} = '0;
		timerOverrun = 1'b0;
	end
	// One-cycle pulses; qualifiers inverted after
	task automatic rx(input logic toBuf, input logic [3:0] obj, input logic [63:0] d);
		@(posedge sys_clk);
		{rxFrameValid, rxFrameToBuffer, rxFrameObj, rxFrameData} <= {1'b1, toBuf, obj, d};
		@(posedge sys_clk);
		{rxFrameValid, rxFrameToBuffer, rxFrameObj, rxFrameData} <= {1'b0, ~toBuf, ~obj, ~d};
	endtask : rx
	task automatic txDone(input logic [3:0] obj);
		@(posedge sys_clk);
		{txDoneValid, txDoneObj} <= {1'b1, obj};
		@(posedge sys_clk);
		{txDoneValid, txDoneObj} <= {1'b0, ~obj};
	endtask : txDone
	task automatic err(input logic isObj, input logic [3:0] obj, input logic [2:0] k,
		input logic whileTx);
		@(posedge sys_clk);
		{errValid, errIsObject, errObj, errKind, errWhileTx} <= {1'b1, isObj, obj, k, whileTx};
		@(posedge sys_clk);
		{errValid, errIsObject, errObj, errKind, errWhileTx} <= {1'b0, ~isObj, ~obj, ~k, ~whileTx};
	endtask : err
	task automatic overrun();
		@(posedge sys_clk);
		timerOverrun <= 1'b1;
		@(posedge sys_clk);
		timerOverrun <= 1'b0;
	endtask : overrun
	task automatic level(input logic v);
		@(posedge sys_clk);
		canRx <= v;
	endtask : level
endmodule : cmb_bus_node
`default_nettype wire

//--- sim/can_mailbox_irq_bit_timing_test.sv
// Self-checking bench for the CAN mailbox block
`timescale 1ns/10ps
`default_nettype none
module can_mailbox_irq_bit_timing_test;
	logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, canRx, rxFrameValid;
	logic rxFrameToBuffer, txDoneValid, errValid, errIsObject, errWhileTx, timerOverrun;
	logic irqOut, timeQuantumTick, sampleTick, bitLevel;
	logic [3:0] avs_address, rxFrameObj, txDoneObj, errObj;
	logic [2:0] errKind;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [63:0] rxFrameData;
	int mismatches = 0;
	int cmpCount = 0;
	int n;
	cmb_mailbox cmb_mailbox_inst (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rxFrameValid(rxFrameValid), .rxFrameToBuffer(rxFrameToBuffer), .rxFrameObj(rxFrameObj),
		.rxFrameData(rxFrameData), .txDoneValid(txDoneValid), .txDoneObj(txDoneObj),
		.errValid(errValid), .errIsObject(errIsObject), .errObj(errObj), .errKind(errKind),
		.errWhileTx(errWhileTx), .timerOverrun(timerOverrun), .canRx(canRx), .irqOut(irqOut),
		.timeQuantumTick(timeQuantumTick), .sampleTick(sampleTick), .bitLevel(bitLevel));
	cmb_bus_node cmb_bus_node_inst (.sys_clk(sys_clk), .canRx(canRx),
		.rxFrameValid(rxFrameValid), .rxFrameToBuffer(rxFrameToBuffer), .rxFrameObj(rxFrameObj),
		.rxFrameData(rxFrameData), .txDoneValid(txDoneValid), .txDoneObj(txDoneObj),
		.errValid(errValid), .errIsObject(errIsObject), .errObj(errObj), .errKind(errKind),
		.errWhileTx(errWhileTx), .timerOverrun(timerOverrun));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{avs_address, avs_writedata, avs_write} <= {a, d, 1'b1};
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : wr
	task automatic rdReg(input logic [3:0] a);
		@(posedge sys_clk);
		{avs_address, avs_read} <= {a, 1'b1};
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
	endtask : rdReg
	task automatic irqIs(input logic exp);
		@(posedge sys_clk);
		chk("irqOut", {31'h0, irqOut}, {31'h0, exp});
	endtask : irqIs
	task automatic gap(input logic smp);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while ((smp ? sampleTick : timeQuantumTick) !== 1'b1 && n < 100);
	endtask : gap
	task automatic conclude();
		if (mismatches == 0 && cmpCount > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic testConfig();
		rdReg(4'hf);
		chk("unmapped", rd, 32'h0);
		wr(cmb_pkg::REG_PAGE, 32'h30);
		for (int c = 0; c < 4; c++) begin
			wr(cmb_pkg::REG_CTRL, 32'(c << 6));
			rdReg(cmb_pkg::REG_CTRL);
			chk("config", {30'h0, rd[7:6]}, 32'(c));
			rdReg(cmb_pkg::REG_ENSUM);
			chk("active", rd, (c == 0) ? 32'h0 : 32'h8);
		end
		wr(cmb_pkg::REG_PAGE, 32'h40);
		rdReg(cmb_pkg::REG_CTRL);
		chk("other page", rd, 32'h0);
		cmb_bus_node_inst.txDone(4'h3);
		rdReg(cmb_pkg::REG_ENSUM);
		chk("tx clears active", rd, 32'h0);
		wr(cmb_pkg::REG_PAGE, 32'h30);
		rdReg(cmb_pkg::REG_STAT);
		chk("tx done", rd, 32'h20);
	endtask : testConfig
	task automatic testData();
		wr(cmb_pkg::REG_PAGE, 32'h10);
		for (int i = 0; i < 8; i++) wr(cmb_pkg::REG_DATA, 32'ha0 + 32'(i));
		for (int i = 0; i < 8; i++) begin
			rdReg(cmb_pkg::REG_DATA);
			chk("data window", rd, 32'ha0 + 32'(i));
		end
		rdReg(cmb_pkg::REG_PAGE);
		chk("pointer wrap", rd, 32'h10);
	endtask : testData
	task automatic testError();
		wr(cmb_pkg::REG_GIE, 32'h82);
		cmb_bus_node_inst.err(1'b1, 4'h6, cmb_pkg::ERR_FORM, 1'b1);
		irqIs(1'b0);
		wr(cmb_pkg::REG_PAGE, 32'h60);
		rdReg(cmb_pkg::REG_STAT);
		chk("form and bit", rd, 32'h12);
		rdReg(cmb_pkg::REG_GIT);
		chk("no general", rd, 32'h0);
		cmb_bus_node_inst.err(1'b0, 4'h0, cmb_pkg::ERR_CRC, 1'b0);
		irqIs(1'b1);
		wr(cmb_pkg::REG_GIT, 32'h1);
		irqIs(1'b0);
		for (int k = 1; k < 5; k++) cmb_bus_node_inst.err(1'b1, 4'h7, 3'(k), 1'b0);
		wr(cmb_pkg::REG_PAGE, 32'h70);
		rdReg(cmb_pkg::REG_STAT);
		chk("object errors", rd, 32'hf);
		wr(cmb_pkg::REG_GIE, 32'h88);
		wr(cmb_pkg::REG_OBJIE, 32'h80);
		irqIs(1'b1);
	endtask : testError
	task automatic testIrq();
		wr(cmb_pkg::REG_PAGE, 32'h40);
		wr(cmb_pkg::REG_CTRL, 32'h80);
		wr(cmb_pkg::REG_GIE, 32'ha0);
		wr(cmb_pkg::REG_OBJIE, 32'h10);
		cmb_bus_node_inst.rx(1'b0, 4'h4, 64'h5);
		irqIs(1'b1);
		rdReg(cmb_pkg::REG_PEND);
		chk("pending", rd, 32'h10);
		wr(cmb_pkg::REG_STAT, 32'h0);
		irqIs(1'b0);
		wr(cmb_pkg::REG_OBJIE, 32'h0);
		wr(cmb_pkg::REG_CTRL, 32'h80);
		cmb_bus_node_inst.rx(1'b0, 4'h4, 64'h6);
		irqIs(1'b0);
		wr(cmb_pkg::REG_GIE, 32'h0);
		wr(cmb_pkg::REG_SYSIE, 32'h1);
		cmb_bus_node_inst.overrun();
		irqIs(1'b1);
		rdReg(cmb_pkg::REG_GIT);
		chk("timer flag", rd, 32'h2);
		wr(cmb_pkg::REG_GIT, 32'h2);
		irqIs(1'b0);
	endtask : testIrq
	task automatic testBuffer();
		wr(cmb_pkg::REG_GIE, 32'h84);
		wr(cmb_pkg::REG_PAGE, 32'h50);
		wr(cmb_pkg::REG_CTRL, 32'hc0);
		wr(cmb_pkg::REG_PAGE, 32'h20);
		wr(cmb_pkg::REG_CTRL, 32'hc0);
		cmb_bus_node_inst.rx(1'b1, 4'h0, 64'h11);
		cmb_bus_node_inst.rx(1'b1, 4'h0, 64'h22);
		irqIs(1'b1);
		rdReg(cmb_pkg::REG_GIT);
		chk("buffer full", rd, 32'h4);
		cmb_bus_node_inst.rx(1'b1, 4'h0, 64'h33);
		rdReg(cmb_pkg::REG_DATA);
		chk("lowest free", rd, 32'h11);
		rdReg(cmb_pkg::REG_STAT);
		chk("rx done", rd, 32'h40);
		wr(cmb_pkg::REG_PAGE, 32'h50);
		rdReg(cmb_pkg::REG_DATA);
		chk("scattered member", rd, 32'h22);
		wr(cmb_pkg::REG_PAGE, 32'h20);
		wr(cmb_pkg::REG_STAT, 32'h0);
		wr(cmb_pkg::REG_CTRL, 32'hc0);
		wr(cmb_pkg::REG_GIT, 32'h4);
		cmb_bus_node_inst.rx(1'b1, 4'h0, 64'h44);
		wr(cmb_pkg::REG_PAGE, 32'h20);
		rdReg(cmb_pkg::REG_DATA);
		chk("after release", rd, 32'h44);
	endtask : testBuffer
	task automatic testTiming();
		wr(cmb_pkg::REG_BT, 32'h0001_2101);
		gap(1'b0);
		gap(1'b0);
		chk("quantum", 32'(n), 32'd2);
		gap(1'b1);
		gap(1'b1);
		chk("bit clocks", 32'(n), 32'd16);
		chk("sampled level", {31'h0, bitLevel}, 32'h1);
		cmb_bus_node_inst.level(1'b0);
		gap(1'b1);
		chk("low level", {31'h0, bitLevel}, 32'h0);
	endtask : testTiming
	// ----------------------------------------
	// Clock, sequence, watchdog
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		{rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		testConfig();
		testData();
		testError();
		testIrq();
		testBuffer();
		testTiming();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		conclude();
	end
endmodule : can_mailbox_irq_bit_timing_test
`default_nettype wire
